// >>> gain_store_consts.vh
// Constants for the motor controller gain parameter store
`ifndef GAIN_STORE_CONSTS_VH
`define GAIN_STORE_CONSTS_VH

// ------------------------------------------------------------
// Subindex map, gain object
// ------------------------------------------------------------
`define GS_SUB_COUNT        8'h00
`define GS_SUB_FIRST_GAIN   8'h01
`define GS_SUB_LAST_GAIN    8'h0C
`define GS_GAIN_COUNT       8'h0C
`define GS_GAIN_NUM         12

// ------------------------------------------------------------
// Gain presets
// ------------------------------------------------------------
`define GS_RST_POS_P        32'h00000800
`define GS_RST_POS_I        32'h00000000
`define GS_RST_SPD_P        32'h00001B58
`define GS_RST_SPD_I        32'h00000004
`define GS_RST_FLD_P        32'h00881EE0
`define GS_RST_FLD_I        32'h0007C740
`define GS_RST_TRQ_P        32'h00881EE0
`define GS_RST_TRQ_I        32'h0007C740
`define GS_RST_OPN_P        32'h0026E440
`define GS_RST_OPN_I        32'h001D2B30
`define GS_RST_SPD_FF       32'h000003E8
`define GS_RST_ACC_FF       32'h00000000

// ------------------------------------------------------------
// Flag object
// ------------------------------------------------------------
`define GS_FLAG_COUNT       8'h03
`define GS_FLAG_SUB_RSVD    8'h01
`define GS_FLAG_SUB_INVERT  8'h02
`define GS_FLAG_SUB_KEEP    8'h03
`define GS_FLAG_RST         8'h00

`endif

// >>> gain_word_reg.v
// One read/write 32-bit entry with its own preset
`default_nettype none
module gain_word_reg #(
   parameter [31:0] RESET_VAL = 32'h00000000
) (
   input  wire        ref_clk_i,
   input  wire        arst_n_i,
   input  wire        we_i,
   input  wire [31:0] wdata_i,
   output wire [31:0] q_o
);
   reg [31:0] q_r;
   always @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         q_r <= RESET_VAL;
      end else if (we_i) begin
         q_r <= wdata_i;
      end
   end
   assign q_o = q_r;
endmodule
`default_nettype wire

// >>> flag_byte_reg.v
// One read/write signed 8-bit flag entry
`include "gain_store_consts.vh"
`default_nettype none
module flag_byte_reg (
   input  wire       ref_clk_i,
   input  wire       arst_n_i,
   input  wire       we_i,
   input  wire [7:0] wdata_i,
   output wire [7:0] q_o
);
   reg [7:0] q_r;
   always @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         q_r <= `GS_FLAG_RST;
      end else if (we_i) begin
         q_r <= wdata_i;
      end
   end
   assign q_o = q_r;
endmodule
`default_nettype wire

// >>> motor_gain_store.v
// Gain parameter store and drive flags of a motor controller
//
// Contract
// - Position P gain: 32-bit RW, preset 0x00000800.
// - Position I gain: 32-bit RW, preset zero.
// - Speed P gain: 32-bit RW, preset 0x00001B58.
// - Speed I gain: 32-bit RW, preset 0x00000004.
// - Closed-loop field current P/I gains, presets 0x00881EE0, 0x0007C740.
// - Closed-loop torque current P/I gains, presets 0x00881EE0, 0x0007C740.
// - Open-loop current P/I gains, presets 0x0026E440 and 0x001D2B30.
// - Speed feed-forward in 0.1 percent units, preset 1000 is unity.
// - Acceleration feed-forward applies both ways; preset zero disables.
// - Flags choose auto setup gain overwrite and field inversion.
// - Inversion change applies only after restart; software reruns setup.
// - Flag object: three signed 8-bit entries reached by subindex.
// - Flag two inverts field; flag three blocks auto setup changes.
`include "gain_store_consts.vh"
`default_nettype none
module motor_gain_store (
   input  wire        ref_clk_i,
   input  wire        arst_n_i,
   // Object access port, gain object
   input  wire        gain_wr_i,
   input  wire        gain_rd_i,
   input  wire [7:0]  gain_sub_i,
   input  wire [31:0] gain_wdata_i,
   output wire [31:0] gain_rdata_o,
   output wire        gain_ack_o,
   output wire        gain_err_o,
   // Object access port, flag object
   input  wire        flag_wr_i,
   input  wire        flag_rd_i,
   input  wire [7:0]  flag_sub_i,
   input  wire [7:0]  flag_wdata_i,
   output wire [7:0]  flag_rdata_o,
   output wire        flag_ack_o,
   output wire        flag_err_o,
   // Auto setup gain update path
   input  wire        setup_wr_i,
   input  wire [7:0]  setup_sub_i,
   input  wire [31:0] setup_wdata_i,
   // Controller restart strobe from the same clock domain
   input  wire        ctrl_restart_i,
   // Gains to the control loops
   output wire [31:0] pos_p_gain_o,
   output wire [31:0] pos_i_gain_o,
   output wire [31:0] spd_p_gain_o,
   output wire [31:0] spd_i_gain_o,
   output wire [31:0] fld_p_gain_o,
   output wire [31:0] fld_i_gain_o,
   output wire [31:0] trq_p_gain_o,
   output wire [31:0] trq_i_gain_o,
   output wire [31:0] opn_p_gain_o,
   output wire [31:0] opn_i_gain_o,
   output wire [31:0] spd_ff_o,
   output wire [31:0] acc_ff_o,
   output wire        acc_ff_en_o,
   output wire        field_invert_o,
   output wire        setup_locked_o
);

   // ---------------------------------------------------------
   // Gain entries
   // ---------------------------------------------------------
   localparam [32*`GS_GAIN_NUM-1:0] PRESETS = {
      `GS_RST_ACC_FF, `GS_RST_SPD_FF, `GS_RST_OPN_I, `GS_RST_OPN_P,
      `GS_RST_TRQ_I,  `GS_RST_TRQ_P,  `GS_RST_FLD_I, `GS_RST_FLD_P,
      `GS_RST_SPD_I,  `GS_RST_SPD_P,  `GS_RST_POS_I, `GS_RST_POS_P};

   wire [32*`GS_GAIN_NUM-1:0] gain_q;
   wire                       setup_locked;
   wire                       gain_sub_ok;
   wire                       setup_sub_ok;

   assign gain_sub_ok  = (gain_sub_i >= `GS_SUB_FIRST_GAIN) &&
                         (gain_sub_i <= `GS_SUB_LAST_GAIN);
   assign setup_sub_ok = (setup_sub_i >= `GS_SUB_FIRST_GAIN) &&
                         (setup_sub_i <= `GS_SUB_LAST_GAIN);

   genvar g;
   generate
      for (g = 0; g < `GS_GAIN_NUM; g = g + 1) begin : gain_slot
         localparam [7:0] SUB_CODE = g + `GS_SUB_FIRST_GAIN;
         wire       bus_hit;
         wire       setup_hit;
         // A read in the same cycle takes priority over the write
         assign bus_hit   = gain_wr_i && !gain_rd_i &&
                            (gain_sub_i == SUB_CODE);
         // Auto setup may only write when not locked out
         assign setup_hit = setup_wr_i && !setup_locked && setup_sub_ok &&
                            (setup_sub_i == SUB_CODE);
         // Bus write wins over auto setup in the same cycle
         gain_word_reg #(
            .RESET_VAL (PRESETS[32*g +: 32])
         ) u_gain (
            .ref_clk_i (ref_clk_i),
            .arst_n_i  (arst_n_i),
            .we_i      (bus_hit | setup_hit),
            .wdata_i   (bus_hit ? gain_wdata_i : setup_wdata_i),
            .q_o       (gain_q[32*g +: 32])
         );
      end
   endgenerate

   // ---------------------------------------------------------
   // Gain object read and answer
   // ---------------------------------------------------------
   reg [31:0] gain_rdata_r;
   reg        gain_ack_r;
   reg        gain_err_r;
   wire [3:0] gain_idx;

   assign gain_idx = gain_sub_i[3:0] - 4'h1;

   always @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         gain_rdata_r <= 32'h00000000;
         gain_ack_r   <= 1'b0;
         gain_err_r   <= 1'b0;
      end else begin
         gain_ack_r <= gain_wr_i | gain_rd_i;
         gain_err_r <= 1'b0;
         if (gain_rd_i) begin
            if (gain_sub_i == `GS_SUB_COUNT) begin
               gain_rdata_r <= {24'h000000, `GS_GAIN_COUNT};
            end else if (gain_sub_ok) begin
               gain_rdata_r <= gain_q[32*gain_idx +: 32];
            end else begin
               gain_rdata_r <= 32'h00000000;
               gain_err_r   <= 1'b1;
            end
         end else if (gain_wr_i) begin
            // Entry count is read only; unknown subindex also refused
            gain_err_r <= !gain_sub_ok;
         end
      end
   end

   assign gain_rdata_o = gain_rdata_r;
   assign gain_ack_o   = gain_ack_r;
   assign gain_err_o   = gain_err_r;

   // ---------------------------------------------------------
   // Flag entries
   // ---------------------------------------------------------
   wire [23:0] flag_q;
   wire        flag_sub_ok;

   assign flag_sub_ok = (flag_sub_i >= `GS_FLAG_SUB_RSVD) &&
                        (flag_sub_i <= `GS_FLAG_SUB_KEEP);

   generate
      for (g = 0; g < 3; g = g + 1) begin : flag_slot
         localparam [7:0] SUB_CODE = g + `GS_FLAG_SUB_RSVD;
         flag_byte_reg u_flag (
            .ref_clk_i (ref_clk_i),
            .arst_n_i  (arst_n_i),
            .we_i      (flag_wr_i && !flag_rd_i &&
                        (flag_sub_i == SUB_CODE)),
            .wdata_i   (flag_wdata_i),
            .q_o       (flag_q[8*g +: 8])
         );
      end
   endgenerate

   reg [7:0] flag_rdata_r;
   reg       flag_ack_r;
   reg       flag_err_r;
   wire [1:0] flag_idx;

   assign flag_idx = flag_sub_i[1:0] - 2'h1;

   always @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         flag_rdata_r <= 8'h00;
         flag_ack_r   <= 1'b0;
         flag_err_r   <= 1'b0;
      end else begin
         flag_ack_r <= flag_wr_i | flag_rd_i;
         flag_err_r <= 1'b0;
         if (flag_rd_i) begin
            if (flag_sub_i == `GS_SUB_COUNT) begin
               flag_rdata_r <= `GS_FLAG_COUNT;
            end else if (flag_sub_ok) begin
               flag_rdata_r <= flag_q[8*flag_idx +: 8];
            end else begin
               flag_rdata_r <= 8'h00;
               flag_err_r   <= 1'b1;
            end
         end else if (flag_wr_i) begin
            flag_err_r <= !flag_sub_ok;
         end
      end
   end

   assign flag_rdata_o = flag_rdata_r;
   assign flag_ack_o   = flag_ack_r;
   assign flag_err_o   = flag_err_r;

   // ---------------------------------------------------------
   // Flag effects
   // ---------------------------------------------------------
   reg field_invert_r;

   // Nonzero entry two latched only on controller restart
   always @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         field_invert_r <= 1'b0;
      end else if (ctrl_restart_i) begin
         field_invert_r <= |flag_q[15:8];
      end
   end

   assign setup_locked   = |flag_q[23:16];
   assign setup_locked_o = setup_locked;
   assign field_invert_o = field_invert_r;

   // ---------------------------------------------------------
   // Gains to the loops
   // ---------------------------------------------------------
   assign pos_p_gain_o = gain_q[31:0];
   assign pos_i_gain_o = gain_q[63:32];
   assign spd_p_gain_o = gain_q[95:64];
   assign spd_i_gain_o = gain_q[127:96];
   assign fld_p_gain_o = gain_q[159:128];
   assign fld_i_gain_o = gain_q[191:160];
   assign trq_p_gain_o = gain_q[223:192];
   assign trq_i_gain_o = gain_q[255:224];
   assign opn_p_gain_o = gain_q[287:256];
   assign opn_i_gain_o = gain_q[319:288];
   assign spd_ff_o     = gain_q[351:320];
   assign acc_ff_o     = gain_q[383:352];
   // Zero factor disables acceleration feed-forward in both directions
   assign acc_ff_en_o  = |gain_q[383:352];

endmodule
`default_nettype wire

// >>> motor_gain_store_assertions.sv
// Checker for the gain parameter store
`default_nettype none
module motor_gain_store_assertions (
   input wire logic        ref_clk_i,
   input wire logic        arst_n_i,
   input wire logic        gain_wr_i,
   input wire logic        gain_rd_i,
   input wire logic [7:0]  gain_sub_i,
   input wire logic [31:0] gain_wdata_i,
   input wire logic [31:0] gain_rdata_o,
   input wire logic        gain_ack_o,
   input wire logic        gain_err_o,
   input wire logic        flag_rd_i,
   input wire logic [7:0]  flag_sub_i,
   input wire logic [7:0]  flag_rdata_o,
   input wire logic        setup_wr_i,
   input wire logic        ctrl_restart_i,
   input wire logic [31:0] pos_p_gain_o,
   input wire logic [31:0] spd_p_gain_o,
   input wire logic [31:0] acc_ff_o,
   input wire logic        acc_ff_en_o,
   input wire logic        field_invert_o,
   input wire logic        setup_locked_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!arst_n_i);
   property p_ack;
      1 |=> gain_ack_o == $past(gain_rd_i | gain_wr_i);
   endproperty
   property p_err0;
      gain_wr_i && !gain_rd_i && gain_sub_i == 8'h00 |=> gain_err_o;
   endproperty
   property p_cnt;
      gain_rd_i && gain_sub_i == 8'h00 |=> gain_rdata_o == 32'h0000000C;
   endproperty
   property p_spd;
      gain_wr_i && !gain_rd_i && gain_sub_i == 8'h03
         |=> spd_p_gain_o == $past(gain_wdata_i);
   endproperty
   property p_rdp;
      gain_rd_i && gain_sub_i == 8'h01 |=> gain_rdata_o == $past(pos_p_gain_o);
   endproperty
   property p_lock;
      setup_locked_o && setup_wr_i && !gain_wr_i |=> $stable(pos_p_gain_o);
   endproperty
   property p_inv;
      !ctrl_restart_i |=> $stable(field_invert_o);
   endproperty
   property p_accen;
      acc_ff_en_o == (acc_ff_o != 32'h00000000);
   endproperty
   property p_fcnt;
      flag_rd_i && flag_sub_i == 8'h00 |=> flag_rdata_o == 8'h03;
   endproperty
   a_ack: assert property (p_ack) else $error("ack timing");
   a_err0: assert property (p_err0) else $error("count write");
   a_cnt: assert property (p_cnt) else $error("count read");
   a_spd: assert property (p_spd) else $error("speed gain write");
   a_rdp: assert property (p_rdp) else $error("position readback");
   a_lock: assert property (p_lock) else $error("locked setup");
   a_inv: assert property (p_inv) else $error("invert early");
   a_accen: assert property (p_accen) else $error("acc enable");
   a_fcnt: assert property (p_fcnt) else $error("flag count");
   c_err: cover property (gain_err_o);
   c_inv: cover property ($rose(field_invert_o));
   c_lock: cover property (setup_locked_o && setup_wr_i);
endmodule
bind motor_gain_store motor_gain_store_assertions i_chk (.ref_clk_i,
   .arst_n_i, .gain_wr_i, .gain_rd_i, .gain_sub_i, .gain_wdata_i,
   .gain_rdata_o, .gain_ack_o, .gain_err_o, .flag_rd_i, .flag_sub_i,
   .flag_rdata_o, .setup_wr_i, .ctrl_restart_i, .pos_p_gain_o,
   .spd_p_gain_o, .acc_ff_o, .acc_ff_en_o, .field_invert_o, .setup_locked_o);
`default_nettype wire

// >>> motor_gain_store_tb.sv
// Self-checking testbench for the gain parameter store
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((e) !== (s)) begin n_fail++; \
   $display("MISMATCH %s exp %h got %h", n, e, s); end end
module motor_gain_store_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        ref_clk_i = 1'b0, arst_n_i = 1'b0;
   logic        gwr = 0, grd = 0, fwr = 0, frd = 0, swr = 0, rst = 0;
   logic [7:0]  gsub = 0, fsub = 0, ssub = 0, fwd = 0, frdat;
   logic [31:0] gwd = 0, swd = 0, grdat, o [1:12], m [0:12], seed;
   logic [7:0]  fm [0:3];
   logic        gack, gerr, fack, ferr, accen, inv, lk;
   logic [33:0] qg [$], qf [$], e;
   int          n_fail = 0, total_checks = 0, cyc = 0, i;
   motor_gain_store i_dut (.ref_clk_i, .arst_n_i, .gain_wr_i(gwr),
      .gain_rd_i(grd), .gain_sub_i(gsub), .gain_wdata_i(gwd),
      .gain_rdata_o(grdat), .gain_ack_o(gack), .gain_err_o(gerr),
      .flag_wr_i(fwr), .flag_rd_i(frd), .flag_sub_i(fsub),
      .flag_wdata_i(fwd), .flag_rdata_o(frdat), .flag_ack_o(fack),
      .flag_err_o(ferr), .setup_wr_i(swr), .setup_sub_i(ssub),
      .setup_wdata_i(swd), .ctrl_restart_i(rst), .pos_p_gain_o(o[1]),
      .pos_i_gain_o(o[2]), .spd_p_gain_o(o[3]), .spd_i_gain_o(o[4]),
      .fld_p_gain_o(o[5]), .fld_i_gain_o(o[6]), .trq_p_gain_o(o[7]),
      .trq_i_gain_o(o[8]), .opn_p_gain_o(o[9]), .opn_i_gain_o(o[10]),
      .spd_ff_o(o[11]), .acc_ff_o(o[12]), .acc_ff_en_o(accen),
      .field_invert_o(inv), .setup_locked_o(lk));
   initial begin
      forever #25 ref_clk_i = ~ref_clk_i;
   end
   task automatic acc(input bit f, input bit r, input logic [7:0] s,
                      input logic [31:0] d);
      bit ok;
      ok = (s <= (f ? 3 : 12)) && (r || s != 8'h00);
      @(negedge ref_clk_i);
      {fwr, frd, gwr, grd} = {f & !r, f & r, !f & !r, !f & r};
      {fsub, gsub, fwd, gwd} = {s, s, d[7:0], d};
      if (f) qf.push_back({r & ok, !ok, 24'h000000, fm[s[1:0]]});
      else qg.push_back({r & ok, !ok, m[s[3:0]]});
      if (ok && !r && f) fm[s[1:0]] = d[7:0];
      if (ok && !r && !f) m[s[3:0]] = d;
   endtask
   task automatic pulse(input bit st, input logic [31:0] d);
      @(negedge ref_clk_i);
      {fwr, frd, gwr, grd} = 4'h0;
      {swr, rst, ssub, swd} = {st, !st, 8'h01, d};
      if (st && fm[3] == 8'h00) m[1] = d;
      @(negedge ref_clk_i);
      {swr, rst} = 2'h0;
      @(negedge ref_clk_i);
   endtask
   task automatic chk_out();
      for (int k = 1; k <= 12; k++) `CHK("gain", m[k], o[k])
      `CHK("acc_ff_en", m[12] != 0, accen)
      `CHK("locked", fm[3] != 0, lk)
   endtask
   always @(negedge ref_clk_i) begin
      if (gack === 1'b1) begin
         e = qg.pop_front();
         `CHK("gain_err", e[32], gerr)
         if (e[33]) `CHK("gain_rdata", e[31:0], grdat)
      end
      if (fack === 1'b1) begin
         e = qf.pop_front();
         `CHK("flag_err", e[32], ferr)
         if (e[33]) `CHK("flag_rdata", e[7:0], frdat)
      end
   end
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         summarize();
      end
   end
   task summarize();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      m = '{32'h0000000C, 32'h00000800, 32'h00000000, 32'h00001B58,
            32'h00000004, 32'h00881EE0, 32'h0007C740, 32'h00881EE0,
            32'h0007C740, 32'h0026E440, 32'h001D2B30, 32'h000003E8,
            32'h00000000};
      fm = '{8'h03, 8'h00, 8'h00, 8'h00};
      seed = $urandom(22687);
      repeat (4) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      arst_n_i = 1'b1;
      chk_out();
      for (i = 0; i <= 13; i++) acc(0, 1, i[7:0], 0);
      for (i = 0; i <= 4; i++) acc(1, 1, i[7:0], 0);
      $display("T1 presets done");
      for (i = 0; i <= 13; i++) acc(0, 0, i[7:0], $urandom);
      for (i = 0; i <= 13; i++) acc(0, 1, i[7:0], 0);
      pulse(1, $urandom);
      chk_out();
      $display("T2 gain writes done");
      acc(1, 0, 2, 32'h00000001);
      acc(1, 0, 0, 32'h00000005);
      acc(1, 0, 3, 32'h00000080);
      pulse(1, $urandom);
      `CHK("invert", 1'b0, inv)
      chk_out();
      pulse(0, 0);
      `CHK("invert", 1'b1, inv)
      acc(1, 0, 3, 32'h00000000);
      acc(1, 0, 2, 32'h00000000);
      for (i = 0; i <= 4; i++) acc(1, 1, i[7:0], 0);
      pulse(1, $urandom);
      `CHK("invert", 1'b1, inv)
      chk_out();
      $display("T3 flags done");
      repeat (2) @(negedge ref_clk_i);
      `CHK("queues", 0, qg.size() + qf.size())
      summarize();
   end
endmodule
`default_nettype wire
